//--- hw/warc_pkg.sv
// Package for the watchdog and reset control block: offsets, reset values, types
package warc_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] WDC_OFFSET     = 8'h00;
  localparam logic [7:0] SCF_OFFSET     = 8'h04;
  localparam logic [7:0] STAT_OFFSET    = 8'h08;
  localparam logic [7:0] IRQ_ST_OFFSET  = 8'h0c;
  localparam logic [7:0] IRQ_MSK_OFFSET = 8'h10;

  // Watchdog control layout and reset value
  localparam logic [7:0] WDC_RESET      = 8'h53;
  localparam int         GUARD_LSB      = 3;
  localparam logic [4:0] GUARD_OK_A     = 5'h0a;
  localparam logic [4:0] GUARD_OK_B     = 5'h15;

  // System control flag bit positions
  localparam int SCF_SOFT_BIT  = 0;
  localparam int SCF_SPARE_BIT = 1;
  localparam int SCF_LVR_BIT   = 2;
  localparam int SCF_FOSC_LSB  = 4;
  localparam int SCF_KEEP_BIT  = 7;
  localparam logic [7:0] SCF_RESET = 8'h00;

  // Status register bit positions (read only)
  localparam int STAT_TO_BIT  = 0;
  localparam int STAT_PDF_BIT = 1;

  // Interrupt status and mask bit positions
  localparam int IRQ_TIMEOUT_BIT = 0;
  localparam int IRQ_SOFT_BIT    = 1;
  localparam int IRQ_LVR_BIT     = 2;
  localparam int IRQ_WIDTH       = 3;

  // Invalid guard debounce, in slow clock ticks
  localparam logic [1:0] GUARD_DEBOUNCE_TICKS = 2'h3;

  // Low-voltage qualification time and system clock rate
  localparam int SYS_CLK_MHZ    = 50;
  localparam int LVR_QUAL_NS    = 120000;
  localparam int LVR_QUAL_CYCLES = (LVR_QUAL_NS * SYS_CLK_MHZ + 999) / 1000;

  localparam int WDT_CNT_W = 19;

  typedef enum logic [2:0] {
    WARC_RUN  = 3'b001,
    WARC_DBNC = 3'b010,
    WARC_FIRE = 3'b100
  } warc_guard_state_t;

  // Reset actions requested from the rest of the device
  typedef struct packed {
    logic full_reset;
    logic pc_sp_clear;
    logic port_preset;
  } warc_rst_act_t;

endpackage

//--- hw/warc_top.sv
// Watchdog timer, reset sources and reset flags with an APB register slave
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Function
// [RQ1] Watchdog counts only ticks of the slow internal oscillator clock.
// [RQ2] Timeout select picks prescale 2^8,2^10,2^12,2^14,2^15,2^16,2^17,2^18.
// [RQ3] Watchdog always runs; no disable, also in sleep or idle.
// [RQ4] Watchdog properly enabled only for guard patterns 01010B or 10101B.
// [RQ5] Other guard values give full reset after 2 to 3 slow clocks.
// [RQ6] Guard reset sets soft reset flag bit 0; only software 0 clears.
// [RQ7] Watchdog control loads 53h on any reset except power-down timeout.
// [RQ8] Overflow while running gives full reset and sets timeout flag.
// [RQ9] Overflow in sleep or idle sets timeout flag, clears only PC, SP.
// [RQ10] Count cleared by invalid guard write, clear instruction or halt.
// [RQ11] Software runs the clear instruction before the timeout elapses.
// [RQ12] Power-on sets PC to zero and all port data, direction to ones.
// [RQ13] Low-voltage held beyond qualification time gives full reset and flag.
// [RQ14] Low-voltage flag bit 2 reads 1 after event; only software 0 clears.
// [RQ15] Low-voltage reset is disabled while in the power-down state.
// [RQ16] Bits 6 and 3 read zero; bit 1 is plain storage.
// [RQ17] Power-down flag set by halt, cleared by power-up or clear instruction.
// [RQ18] Timeout when count reaches prescale ratio; clear restarts from zero.
module warc_top #(
  parameter int LVR_QUAL_CYCLES = warc_pkg::LVR_QUAL_CYCLES
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  input  wire logic                   slow_osc_clk,
  input  wire logic                   low_voltage_detect,
  input  wire logic                   clear_watchdog_instruction,
  input  wire logic                   halt_instruction,
  input  wire logic                   core_sleeping,
  output warc_pkg::warc_rst_act_t     rst_act,
  output logic                        idle_sysclk_keep,
  output logic [1:0]                  fast_osc_select,
  output logic                        irq
);

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0]                         wdc_reg;
  logic [7:0]                         wdc_next;
  logic [7:0]                         scf_reg;
  logic [7:0]                         scf_next;
  logic                               to_reg;
  logic                               to_next;
  logic                               pdf_reg;
  logic                               pdf_next;
  logic [warc_pkg::IRQ_WIDTH-1:0]     irq_st_reg;
  logic [warc_pkg::IRQ_WIDTH-1:0]     irq_st_next;
  logic [warc_pkg::IRQ_WIDTH-1:0]     irq_msk_reg;
  logic [warc_pkg::WDT_CNT_W-1:0]     cnt_reg;
  logic [warc_pkg::WDT_CNT_W-1:0]     cnt_next;
  logic [1:0]                         dbnc_reg;
  logic [1:0]                         dbnc_next;
  warc_pkg::warc_guard_state_t        gst_reg;
  warc_pkg::warc_guard_state_t        gst_next;
  logic [31:0]                        lvr_cnt_reg;
  logic [31:0]                        lvr_cnt_next;
  logic                               lvr_fired_reg;
  warc_pkg::warc_rst_act_t            act_reg;
  warc_pkg::warc_rst_act_t            act_next;
  logic [31:0]                        prdata_reg;
  logic                               osc_s1_reg;
  logic                               osc_s2_reg;
  logic                               osc_s3_reg;
  logic                               lvd_s1_reg;
  logic                               lvd_s2_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Synchronisers; first stages feed only the second stages

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
      lvd_s1_reg <= 1'b0;
      lvd_s2_reg <= 1'b0;
    end else begin
      osc_s1_reg <= slow_osc_clk;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
      lvd_s1_reg <= low_voltage_detect;
      lvd_s2_reg <= lvd_s1_reg;
    end
  end

  // One tick per rising slow clock edge; independent of the system clock select
  wire slow_tick = osc_s2_reg & ~osc_s3_reg;  // see [RQ1]

  //////////////////////////////////////////////////////////////////////////////
  // APB decode

  wire apb_acc     = psel & penable;
  wire apb_wr      = apb_acc & pwrite;
  wire sel_wdc     = (paddr == warc_pkg::WDC_OFFSET);
  wire sel_scf     = (paddr == warc_pkg::SCF_OFFSET);
  wire sel_stat    = (paddr == warc_pkg::STAT_OFFSET);
  wire sel_irq_st  = (paddr == warc_pkg::IRQ_ST_OFFSET);
  wire sel_irq_msk = (paddr == warc_pkg::IRQ_MSK_OFFSET);
  wire mapped      = sel_wdc | sel_scf | sel_stat | sel_irq_st | sel_irq_msk;
  wire wr_wdc      = apb_wr & sel_wdc;
  wire wr_scf      = apb_wr & sel_scf;
  wire wr_irq_st   = apb_wr & sel_irq_st;
  wire wr_irq_msk  = apb_wr & sel_irq_msk;

  //////////////////////////////////////////////////////////////////////////////
  // Guard field check and debounce

  wire [4:0] guard_field    = wdc_reg[7:warc_pkg::GUARD_LSB];
  wire [4:0] guard_wr_value = pwdata[7:warc_pkg::GUARD_LSB];
  wire       guard_ok       = (guard_field == warc_pkg::GUARD_OK_A) |
                              (guard_field == warc_pkg::GUARD_OK_B);  // see [RQ4]
  wire       guard_wr_bad   = wr_wdc & (guard_wr_value != warc_pkg::GUARD_OK_A) &
                              (guard_wr_value != warc_pkg::GUARD_OK_B);

  // Ticks are counted from the first edge seen while invalid, so the actual
  // delay lands between two and three slow clock periods after the write.
  always_comb begin
    gst_next  = gst_reg;
    dbnc_next = dbnc_reg;
    case (gst_reg)
      warc_pkg::WARC_RUN: begin
        dbnc_next = 2'h0;
        if (!guard_ok) begin
          gst_next = warc_pkg::WARC_DBNC;
        end
      end
      warc_pkg::WARC_DBNC: begin
        if (guard_ok) begin
          gst_next = warc_pkg::WARC_RUN;
        end else if (slow_tick) begin
          dbnc_next = dbnc_reg + 2'h1;
          if (dbnc_reg + 2'h1 == warc_pkg::GUARD_DEBOUNCE_TICKS) begin
            gst_next = warc_pkg::WARC_FIRE;  // see [RQ5]
          end
        end
      end
      warc_pkg::WARC_FIRE: begin
        gst_next = warc_pkg::WARC_RUN;
      end
      default: begin
        gst_next = warc_pkg::WARC_RUN;
      end
    endcase
  end

  wire guard_reset = (gst_reg == warc_pkg::WARC_FIRE);

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog counter

  logic [4:0] ratio_exp;
  always_comb begin
    case (wdc_reg[2:0])  // see [RQ2]
      3'h0:    ratio_exp = 5'h08;
      3'h1:    ratio_exp = 5'h0a;
      3'h2:    ratio_exp = 5'h0c;
      3'h3:    ratio_exp = 5'h0e;
      3'h4:    ratio_exp = 5'h0f;
      3'h5:    ratio_exp = 5'h10;
      3'h6:    ratio_exp = 5'h11;
      default: ratio_exp = 5'h12;
    endcase
  end

  wire [warc_pkg::WDT_CNT_W-1:0] ratio     = (warc_pkg::WDT_CNT_W)'(1) << ratio_exp;
  wire [warc_pkg::WDT_CNT_W-1:0] cnt_inc   = cnt_reg + (warc_pkg::WDT_CNT_W)'(1);
  // No enable term: the count advances in every mode, sleep and idle included
  wire                           overflow  = slow_tick & (cnt_inc == ratio);  // see [RQ3] see [RQ18]
  wire                           asleep    = core_sleeping;
  wire                           to_full   = overflow & ~asleep;  // see [RQ8]
  wire                           to_wake   = overflow & asleep;   // see [RQ9]

  //////////////////////////////////////////////////////////////////////////////
  // Low-voltage qualification

  // Power-down holds the qualifier cleared, so no reset can be raised then
  wire lvd_active = lvd_s2_reg & ~asleep;  // see [RQ15]
  wire lvr_reset  = lvd_active & ~lvr_fired_reg &
                    (lvr_cnt_reg == 32'(LVR_QUAL_CYCLES - 1));  // see [RQ13]

  always_comb begin
    lvr_cnt_next = 32'h0;
    if (lvd_active && lvr_cnt_reg != 32'(LVR_QUAL_CYCLES - 1)) begin
      lvr_cnt_next = lvr_cnt_reg + 32'h1;
    end else if (lvd_active) begin
      lvr_cnt_next = lvr_cnt_reg;
    end
  end

  wire full_reset = guard_reset | to_full | lvr_reset;

  always_comb begin
    cnt_next = cnt_reg;
    if (full_reset || to_wake || guard_wr_bad ||
        clear_watchdog_instruction || halt_instruction) begin
      cnt_next = '0;  // see [RQ10] see [RQ18]
    end else if (overflow) begin
      cnt_next = '0;
    end else if (slow_tick) begin
      cnt_next = cnt_inc;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control and flag registers

  always_comb begin
    wdc_next = wdc_reg;
    if (wr_wdc) begin
      wdc_next = pwdata[7:0];
    end
    // A wake-up timeout leaves the control value untouched
    if (full_reset) begin
      wdc_next = warc_pkg::WDC_RESET;  // see [RQ7]
    end
  end

  always_comb begin
    scf_next = scf_reg;
    if (wr_scf) begin
      scf_next[warc_pkg::SCF_KEEP_BIT]                       = pwdata[warc_pkg::SCF_KEEP_BIT];
      scf_next[warc_pkg::SCF_FOSC_LSB+1:warc_pkg::SCF_FOSC_LSB] =
        pwdata[warc_pkg::SCF_FOSC_LSB+1:warc_pkg::SCF_FOSC_LSB];
      scf_next[warc_pkg::SCF_SPARE_BIT]                      = pwdata[warc_pkg::SCF_SPARE_BIT];  // see [RQ16]
      // Sticky flags accept only a clearing write
      if (!pwdata[warc_pkg::SCF_LVR_BIT]) begin
        scf_next[warc_pkg::SCF_LVR_BIT] = 1'b0;  // see [RQ14]
      end
      if (!pwdata[warc_pkg::SCF_SOFT_BIT]) begin
        scf_next[warc_pkg::SCF_SOFT_BIT] = 1'b0;  // see [RQ6]
      end
    end
    if (full_reset) begin
      scf_next[warc_pkg::SCF_KEEP_BIT]                          = 1'b0;
      scf_next[warc_pkg::SCF_FOSC_LSB+1:warc_pkg::SCF_FOSC_LSB] = 2'h0;
      scf_next[warc_pkg::SCF_SPARE_BIT]                         = 1'b0;
    end
    // Hardware set wins over a simultaneous software clear
    if (lvr_reset) begin
      scf_next[warc_pkg::SCF_LVR_BIT] = 1'b1;  // see [RQ14]
    end
    if (guard_reset) begin
      scf_next[warc_pkg::SCF_SOFT_BIT] = 1'b1;  // see [RQ6]
    end
    scf_next[6] = 1'b0;  // see [RQ16]
    scf_next[3] = 1'b0;
  end

  always_comb begin
    to_next  = to_reg;
    pdf_next = pdf_reg;
    if (clear_watchdog_instruction) begin
      to_next  = 1'b0;
      pdf_next = 1'b0;  // see [RQ17]
    end
    if (halt_instruction) begin
      to_next  = 1'b0;
      pdf_next = 1'b1;  // see [RQ17]
    end
    if (overflow) begin
      to_next = 1'b1;  // see [RQ8] see [RQ9]
    end
  end

  wire [warc_pkg::IRQ_WIDTH-1:0] irq_ev;
  assign irq_ev[warc_pkg::IRQ_TIMEOUT_BIT] = overflow;
  assign irq_ev[warc_pkg::IRQ_SOFT_BIT]    = guard_reset;
  assign irq_ev[warc_pkg::IRQ_LVR_BIT]     = lvr_reset;

  always_comb begin
    irq_st_next = irq_st_reg;
    if (wr_irq_st) begin
      irq_st_next = irq_st_reg & ~pwdata[warc_pkg::IRQ_WIDTH-1:0];
    end
    irq_st_next = irq_st_next | irq_ev;
  end

  // Reset action pulses; power-on raises all three from the asynchronous reset
  always_comb begin
    act_next             = '0;
    act_next.full_reset  = full_reset;
    act_next.pc_sp_clear = full_reset | to_wake;  // see [RQ9]
    act_next.port_preset = full_reset;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data

  wire [7:0] stat_view = {6'h00, pdf_reg, to_reg};
  wire [31:0] rd_mux =
    sel_wdc     ? {24'h0, wdc_reg} :
    sel_scf     ? {24'h0, scf_reg} :
    sel_stat    ? {24'h0, stat_view} :
    sel_irq_st  ? {29'h0, irq_st_reg} :
    sel_irq_msk ? {29'h0, irq_msk_reg} : 32'h0;

  //////////////////////////////////////////////////////////////////////////////
  // State update

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wdc_reg     <= warc_pkg::WDC_RESET;  // see [RQ7]
      scf_reg     <= warc_pkg::SCF_RESET;
      to_reg      <= 1'b0;
      pdf_reg     <= 1'b0;  // see [RQ17]
      cnt_reg     <= '0;
      dbnc_reg    <= 2'h0;
      gst_reg     <= warc_pkg::WARC_RUN;
      irq_st_reg  <= '0;
      irq_msk_reg <= '0;
    end else begin
      wdc_reg     <= wdc_next;
      scf_reg     <= scf_next;
      to_reg      <= to_next;
      pdf_reg     <= pdf_next;
      cnt_reg     <= cnt_next;
      dbnc_reg    <= dbnc_next;
      gst_reg     <= gst_next;
      irq_st_reg  <= irq_st_next;
      irq_msk_reg <= wr_irq_msk ? pwdata[warc_pkg::IRQ_WIDTH-1:0] : irq_msk_reg;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lvr_cnt_reg   <= 32'h0;
      lvr_fired_reg <= 1'b0;
      // PC to zero and ports to all ones as inputs on power-on
      act_reg       <= '1;  // see [RQ12]
      prdata_reg    <= 32'h0;
    end else begin
      lvr_cnt_reg   <= lvr_cnt_next;
      lvr_fired_reg <= lvr_reset | (lvr_fired_reg & lvd_active);
      act_reg       <= act_next;
      prdata_reg    <= (psel & ~penable & ~pwrite) ? rd_mux : prdata_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign pready           = 1'b1;
  assign pslverr          = apb_acc & ~mapped;
  assign prdata           = prdata_reg;
  assign rst_act          = act_reg;
  assign idle_sysclk_keep = scf_reg[warc_pkg::SCF_KEEP_BIT];
  assign fast_osc_select  = scf_reg[warc_pkg::SCF_FOSC_LSB+1:warc_pkg::SCF_FOSC_LSB];
  assign irq              = |(irq_st_reg & irq_msk_reg);

endmodule

//--- testbench/warc_chk.sv
// Port-level assertions for the watchdog and reset control block
`timescale 1ns/1ns
module warc_chk #(
  parameter int LVR_QUAL_CYCLES = warc_pkg::LVR_QUAL_CYCLES
) (
  input wire logic                    sys_clk,
  input wire logic                    rst,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [7:0]              paddr,
  input wire logic [31:0]             pwdata,
  input wire logic                    pready,
  input wire logic [31:0]             prdata,
  input wire logic                    pslverr,
  input wire logic                    low_voltage_detect,
  input wire logic                    core_sleeping,
  input wire warc_pkg::warc_rst_act_t rst_act
);
  // Guard window assumes the bench's slow clock of eight system cycles
  localparam int GMAX = 16;
  int   lv_cnt;
  logic lv_fired;
  logic bad_guard_wr;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  assign bad_guard_wr = psel && penable && pwrite && paddr == warc_pkg::WDC_OFFSET &&
                        pwdata[7:3] != warc_pkg::GUARD_OK_A && pwdata[7:3] != warc_pkg::GUARD_OK_B;

  ////////////////////////////////////////////////////////////////////////////////
  // Raw low-supply time while awake; margin covers the two-stage synchroniser
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lv_cnt   <= 0;
      lv_fired <= 1'b0;
    end else begin
      lv_cnt   <= (low_voltage_detect && !core_sleeping) ? lv_cnt + 1 : 0;
      lv_fired <= (lv_cnt != 0) && (lv_fired || rst_act.full_reset);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  act_pulse_a: assert property (rst_act != 3'b000 |=> rst_act == 3'b000)
    else $error("reset action longer than one cycle");
  full_all_a: assert property (rst_act.full_reset |-> rst_act.pc_sp_clear && rst_act.port_preset)
    else $error("full reset without pc and port preset");
  sleep_only_a: assert property (rst_act == 3'b010 |-> $past(core_sleeping))
    else $error("partial reset while awake");
  guard_dbnc_a: assert property (bad_guard_wr |=> !rst_act.full_reset [*8] ##1 !rst_act.full_reset [*8]
    ##[1:GMAX] rst_act.full_reset)
    else $error("guard reset outside debounce window");
  lvr_qual_a: assert property (lv_cnt == LVR_QUAL_CYCLES + 8 |-> lv_fired)
    else $error("long low supply gave no reset");
  spare_bits_a: assert property (psel && penable && !pwrite && paddr == warc_pkg::SCF_OFFSET
    |-> prdata[31:8] == 24'h0 && !prdata[6] && !prdata[3])
    else $error("unimplemented flag bits read nonzero");
  ready_now_a: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  err_zero_a: assert property (pslverr |-> psel && penable && (pwrite || prdata == 32'h0))
    else $error("error response misplaced or with data");

  cover property (rst_act == 3'b010);
  cover property (rst_act.full_reset && lv_fired);
  cover property (pslverr);
endmodule

//--- testbench/test_watchdog_and_reset_control.sv
// Self-checking bench for the watchdog and reset control block
`timescale 1ns/1ns
module test_watchdog_and_reset_control;
  localparam int         QUAL = 20;
  localparam logic [7:0] WDC  = warc_pkg::WDC_OFFSET;
  localparam logic [7:0] SCF  = warc_pkg::SCF_OFFSET;
  localparam logic [7:0] STA  = warc_pkg::STAT_OFFSET;
  localparam logic [7:0] IST  = warc_pkg::IRQ_ST_OFFSET;
  localparam logic [7:0] IMS  = warc_pkg::IRQ_MSK_OFFSET;
  logic        sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, slow_osc_clk = 0;
  logic        low_voltage_detect = 0, clear_watchdog_instruction = 0, halt_instruction = 0, core_sleeping = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, d;
  logic        pready, pslverr, idle_sysclk_keep, irq;
  logic [1:0]  fast_osc_select;
  logic [2:0]  div = 3'h0;
  logic [2:0]  exp_q[$];
  int          error_cnt = 0, total_checks = 0, seed = 59, n;
  warc_pkg::warc_rst_act_t rst_act;

  warc_top #(.LVR_QUAL_CYCLES(QUAL)) dut (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .slow_osc_clk(slow_osc_clk),
    .low_voltage_detect(low_voltage_detect), .clear_watchdog_instruction(clear_watchdog_instruction),
    .halt_instruction(halt_instruction), .core_sleeping(core_sleeping), .rst_act(rst_act),
    .idle_sysclk_keep(idle_sysclk_keep), .fast_osc_select(fast_osc_select), .irq(irq)
  );

  always #10 sys_clk = ~sys_clk;
  // Slow clock of eight system cycles keeps the longest timeout runs short
  always @(posedge sys_clk) begin
    div          <= div + 3'h1;
    slow_osc_clk <= div[2];
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      error_cnt++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q,
                     output logic err);
    int k;
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, wd, q, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] want, input logic want_err);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    check(q, want);
    check(e, want_err);
  endtask

  task automatic pulse(input logic halt);
    halt_instruction           <= halt;
    clear_watchdog_instruction <= !halt;
    @(posedge sys_clk);
    halt_instruction           <= 1'b0;
    clear_watchdog_instruction <= 1'b0;
  endtask

  task automatic drain(input int lim);
    n = 0;
    while (exp_q.size() != 0 && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    check(exp_q.size(), 0);
  endtask

  task automatic to_run(input logic [7:0] w, input logic slp, input logic [2:0] act, input int tk);
    core_sleeping <= slp;
    wr(WDC, w);
    pulse(slp);
    exp_q.push_back(act);
    drain(tk * 8 + 200);
    check(n >= tk * 8 - 16 && n <= tk * 8 + 24, 1'b1);
    rd_chk(STA, {30'h0, slp, 1'b1}, 1'b0);
    rd_chk(WDC, slp ? {24'h0, w} : 32'h53, 1'b0);
    core_sleeping <= 1'b0;
  endtask

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Any reset action pulse must match the oldest expected one
  always @(posedge sys_clk) begin
    if (!rst && rst_act !== 3'b000) begin
      if (exp_q.size() == 0) check(rst_act, 3'b000);
      else check(rst_act, exp_q.pop_front());
    end
  end

  initial begin
    exp_q.push_back(3'b111);
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk(WDC, 32'h53, 1'b0);
    rd_chk(SCF, 32'h0, 1'b0);
    rd_chk(STA, 32'h0, 1'b0);
    rd_chk(8'h14, 32'h0, 1'b1);
    repeat (4) begin
      d = $random(seed);
      wr(SCF, d);
      rd_chk(SCF, d & 32'hb2, 1'b0);
      check({idle_sysclk_keep, fast_osc_select}, {d[7], d[5:4]});
    end
    $display("Register test finished");
    to_run(8'h50, 1'b0, 3'b111, 256);
    to_run(8'h51, 1'b1, 3'b010, 1024);
    pulse(1'b0);
    rd_chk(STA, 32'h0, 1'b0);
    rd_chk(IST, 32'h1, 1'b0);
    wr(IMS, 32'h1);
    rd_chk(IMS, 32'h1, 1'b0);
    check(irq, 1'b1);
    wr(IST, 32'h1);
    rd_chk(IST, 32'h0, 1'b0);
    check(irq, 1'b0);
    $display("Timeout test finished");
    wr(WDC, 32'h50);
    repeat (4) begin
      repeat (1440) @(posedge sys_clk);
      pulse(1'b0);
    end
    wr(WDC, 32'h03);
    exp_q.push_back(3'b111);
    drain(100);
    // Two to three slow periods of eight cycles, plus synchroniser and pulse latency
    check(n >= 16 && n <= 32, 1'b1);
    rd_chk(SCF, 32'h1, 1'b0);
    rd_chk(WDC, 32'h53, 1'b0);
    wr(SCF, 32'h1);
    rd_chk(SCF, 32'h1, 1'b0);
    wr(SCF, 32'h0);
    rd_chk(SCF, 32'h0, 1'b0);
    wr(WDC, 32'had);
    rd_chk(WDC, 32'had, 1'b0);
    $display("Guard test finished");
    low_voltage_detect <= 1'b1;
    repeat (QUAL / 2) @(posedge sys_clk);
    low_voltage_detect <= 1'b0;
    core_sleeping      <= 1'b1;
    repeat (30) @(posedge sys_clk);
    low_voltage_detect <= 1'b1;
    repeat (QUAL * 3) @(posedge sys_clk);
    exp_q.push_back(3'b111);
    core_sleeping <= 1'b0;
    drain(QUAL + 40);
    check(n >= QUAL && n <= QUAL + 10, 1'b1);
    low_voltage_detect <= 1'b0;
    rd_chk(SCF, 32'h4, 1'b0);
    wr(SCF, 32'h4);
    rd_chk(SCF, 32'h4, 1'b0);
    wr(SCF, 32'h0);
    rd_chk(SCF, 32'h0, 1'b0);
    rd_chk(IST, 32'h6, 1'b0);
    $display("Low-voltage test finished");
    test_done;
  end

  initial begin
    #1000000;
    error_cnt++;
    test_done;
  end
endmodule

bind warc_top warc_chk #(.LVR_QUAL_CYCLES(LVR_QUAL_CYCLES)) chk (
  .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .low_voltage_detect(low_voltage_detect), .core_sleeping(core_sleeping), .rst_act(rst_act)
);
